/* fbe_pkg.sv */
package fbe_pkg;

  // command codes written on the low data byte
  localparam logic [7:0] CMD_UNLOCK1     = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2     = 8'h55;
  localparam logic [7:0] CMD_BYPASS      = 8'h20;
  localparam logic [7:0] CMD_PROGRAM     = 8'ha0;
  localparam logic [7:0] CMD_BYP_EXIT1   = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2   = 8'h00;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE  = 8'h10;
  localparam logic [7:0] CMD_SECT_ERASE  = 8'h30;
  localparam logic [7:0] CMD_CFI         = 8'h98;
  localparam logic [7:0] CMD_RESET       = 8'hf0;

  // unlock and query addresses
  localparam logic [18:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2 = 19'h002aa;
  localparam logic [18:0] ADDR_CFI     = 19'h00055;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;

  // bus timing in ns and derived cycles at 100 MHz
  localparam int CLK_NS       = 10;
  localparam int WR_LOW_NS    = 40;
  localparam int WR_HIGH_NS   = 30;
  localparam int WR_LOW_CYC   = (WR_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_HIGH_CYC  = (WR_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // sector load window; stay below it with margin (longest time rounds down)
  localparam int SECT_WIN_US  = 80;
  localparam int SECT_WIN_CYC = SECT_WIN_US * 1000 / CLK_NS;

  // user command codes
  typedef enum logic [2:0] {
    FBE_OP_PROGRAM    = 3'h0,
    FBE_OP_CHIP_ERASE = 3'h1,
    FBE_OP_SECT_ERASE = 3'h2,
    FBE_OP_BYP_ENTER  = 3'h3,
    FBE_OP_BYP_EXIT   = 3'h4,
    FBE_OP_CFI        = 3'h5,
    FBE_OP_RESET      = 3'h6
  } fbe_op_t;

endpackage

/* fbe_bus_write.sv */
`timescale 1ns/1ps
// one asynchronous write cycle on the flash pins: strobes low, then high
module fbe_bus_write
(
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       clk_en,
  input  wire logic                       start,
  input  wire logic [fbe_pkg::ADDR_W-1:0] addr,
  input  wire logic [fbe_pkg::DATA_W-1:0] data,
  output logic                            busy,
  output logic                            done,
  output logic                            fl_we_n,
  output logic                            fl_ce_n,
  output logic [fbe_pkg::ADDR_W-1:0]      fl_addr,
  output logic [fbe_pkg::DATA_W-1:0]      fl_dq_out,
  output logic                            fl_dq_oe_n
);

  typedef enum logic [1:0] {FBW_IDLE, FBW_LOW, FBW_HIGH} fbw_state_t;

  fbw_state_t                 state_r, state_nxt;
  logic [3:0]                 cnt_r, cnt_nxt;
  logic [fbe_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [fbe_pkg::DATA_W-1:0] data_r, data_nxt;
  logic                       strobe_r, strobe_nxt;
  logic                       done_r, done_nxt;

  // next state of the strobe sequencer
  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    addr_nxt   = addr_r;
    data_nxt   = data_r;
    strobe_nxt = strobe_r;
    done_nxt   = 1'b0;
    unique case (state_r)
      FBW_IDLE:
        if (start)
        begin
          addr_nxt   = addr;
          data_nxt   = data;
          strobe_nxt = 1'b1;
          cnt_nxt    = 4'(fbe_pkg::WR_LOW_CYC - 1);
          state_nxt  = FBW_LOW;
        end
      FBW_LOW:
        if (cnt_r == 4'h0)
        begin
          strobe_nxt = 1'b0;          // rising edge latches the command
          cnt_nxt    = 4'(fbe_pkg::WR_HIGH_CYC - 1);
          state_nxt  = FBW_HIGH;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
      FBW_HIGH:
        if (cnt_r == 4'h0)
        begin
          done_nxt  = 1'b1;
          state_nxt = FBW_IDLE;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
    endcase
  end

  // register stage
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r  <= FBW_IDLE;
      cnt_r    <= 4'h0;
      addr_r   <= '0;
      data_r   <= '0;
      strobe_r <= 1'b0;
      done_r   <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      strobe_r <= strobe_nxt;
      done_r   <= done_nxt;
    end
  end

  assign busy       = (state_r != FBW_IDLE);
  assign done       = done_r;
  assign fl_we_n    = ~strobe_r;
  assign fl_ce_n    = ~strobe_r;
  assign fl_addr    = addr_r;
  assign fl_dq_out  = data_r;
  assign fl_dq_oe_n = (state_r == FBW_IDLE); // drive data through the whole cycle

  // write cycle shape: strobes low four clocks, then high three
  sequence s_strobe_low;
    !fl_we_n [*4];
  endsequence
  sequence s_strobe_high;
    fl_we_n [*3];
  endsequence
  property p_write_shape;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && state_r == FBW_IDLE && start) |=> s_strobe_low ##1 s_strobe_high;
  endproperty
  a_write_shape: assert property (p_write_shape) else $error("bad write strobe shape"); // R12
  property p_data_with_strobe;
    @(posedge ref_clk) disable iff (!reset_n)
      !fl_we_n |-> (!fl_ce_n && !fl_dq_oe_n);
  endproperty
  a_data_with_strobe: assert property (p_data_with_strobe) else $error("strobe without data"); // R17

endmodule

/* fbe_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// R01: bypass entry is two unlocks then 20h
// R02: bypass program is A0h then address/data
// R03: in bypass only bypass commands are issued
// R04: bypass exit is 90h then 00h
// R05: no bypass entry/program while secure sector enabled
// R06: bypass chip erase is 80h then 10h
// R07: bypass chip erase is never suspended
// R08: query allowed while in bypass mode
// R09: chip erase is six ordered write cycles
// R10: device erases alone; host just waits
// R11: after hardware reset reissue the whole sequence
// R12: erase starts at final strobe rising edge
// R13: progress seen on poll, toggle and ready/busy
// R14: during erase host issues no other commands
// R15: after erase host changes address before reading
// R16: sector erase is six cycles ending 30h
// R17: sector address held through the last cycle
// R18: extra sectors repeat last cycle within 80 us
// R19: device window timer restarts per sector write
// R20: sector loads issued back to back, uninterrupted
// R21: unselected and protected sectors untouched by device
// R22: device accepts repeated erase suspend/resume
// R23: during program host issues no other commands
// R24: ready/busy shows busy until array read
module fbe_ctrl
(
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire fbe_pkg::fbe_op_t            cmd_op,
  input  wire logic [fbe_pkg::ADDR_W-1:0]  cmd_addr,
  input  wire logic [fbe_pkg::DATA_W-1:0]  cmd_data,
  input  wire logic                        cmd_more,
  input  wire logic                        secure_sector,
  output logic                             cmd_done,
  output logic                             cmd_rejected,
  output logic                             bypass_active,
  output logic                             fl_we_n,
  output logic                             fl_ce_n,
  output logic                             fl_reset_n,
  output logic [fbe_pkg::ADDR_W-1:0]       fl_addr,
  output logic [fbe_pkg::DATA_W-1:0]       fl_dq_out,
  output logic                             fl_dq_oe_n,
  input  wire logic                        ready_busy_out
);

  typedef enum logic [2:0] {FBE_IDLE, FBE_ISSUE, FBE_WAIT_BUSY, FBE_WAIT_READY,
                            FBE_SECT_MORE} fbe_state_t;

  fbe_state_t                 state_r, state_nxt;
  logic [2:0]                 idx_r, idx_nxt;
  logic [2:0]                 len_r, len_nxt;
  fbe_pkg::fbe_op_t           op_r, op_nxt;
  logic [fbe_pkg::ADDR_W-1:0] caddr_r, caddr_nxt;
  logic [fbe_pkg::DATA_W-1:0] cdata_r, cdata_nxt;
  logic                       byp_r, byp_nxt;
  logic                       more_r, more_nxt;
  logic                       done_r, done_nxt;
  logic                       rej_r, rej_nxt;
  logic [3:0]                 wait_r, wait_nxt;
  logic                       rb_meta_r, rb_sync_r;

  logic                       wr_start;
  logic                       wr_busy;
  logic                       wr_done;
  logic [fbe_pkg::ADDR_W-1:0] seq_addr;
  logic [7:0]                 seq_data;
  logic [fbe_pkg::DATA_W-1:0] seq_word;
  logic                       accept;
  logic                       last_cycle;

  // ready/busy pin passes two flops before use
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rb_meta_r <= 1'b1;
      rb_sync_r <= 1'b1;
    end
    else if (clk_en)
    begin
      rb_meta_r <= ready_busy_out;
      rb_sync_r <= rb_meta_r;
    end
  end

  // sequence length of each operation, bypass forms are shorter
  function automatic logic [2:0] seq_len(input fbe_pkg::fbe_op_t op, input logic byp);
    logic [2:0] n;
    n = 3'd1;
    unique case (op)
      fbe_pkg::FBE_OP_PROGRAM:    n = byp ? 3'd2 : 3'd4;  // R02
      fbe_pkg::FBE_OP_CHIP_ERASE: n = byp ? 3'd2 : 3'd6;  // R06 R09
      fbe_pkg::FBE_OP_SECT_ERASE: n = 3'd6;               // R16
      fbe_pkg::FBE_OP_BYP_ENTER:  n = 3'd3;               // R01
      fbe_pkg::FBE_OP_BYP_EXIT:   n = 3'd2;               // R04
      fbe_pkg::FBE_OP_CFI:        n = 3'd1;               // R08
      fbe_pkg::FBE_OP_RESET:      n = 3'd1;
    endcase
    return n;
  endfunction

  // legal commands given mode and secure sector state
  always_comb
  begin
    accept = 1'b1;
    unique case (cmd_op)
      fbe_pkg::FBE_OP_BYP_ENTER:  accept = !byp_r && !secure_sector;  // R05
      fbe_pkg::FBE_OP_PROGRAM:    accept = !(byp_r && secure_sector); // R05
      fbe_pkg::FBE_OP_SECT_ERASE: accept = !byp_r;                    // R03
      fbe_pkg::FBE_OP_RESET:      accept = !byp_r;                    // R03
      fbe_pkg::FBE_OP_BYP_EXIT:   accept = byp_r;
      default:                    accept = 1'b1;
    endcase
  end

  // address and data of the current write cycle
  always_comb
  begin
    seq_addr = fbe_pkg::ADDR_UNLOCK1;
    seq_data = fbe_pkg::CMD_UNLOCK1;
    last_cycle = (idx_r == len_r - 3'd1);
    if (op_r == fbe_pkg::FBE_OP_BYP_EXIT)
    begin
      seq_addr = caddr_r;                                   // R04
      seq_data = (idx_r == 3'd0) ? fbe_pkg::CMD_BYP_EXIT1 : fbe_pkg::CMD_BYP_EXIT2;
    end
    else if (op_r == fbe_pkg::FBE_OP_CFI)
    begin
      seq_addr = fbe_pkg::ADDR_CFI;                         // R08
      seq_data = fbe_pkg::CMD_CFI;
    end
    else if (op_r == fbe_pkg::FBE_OP_RESET)
      seq_data = fbe_pkg::CMD_RESET;
    else if (len_r == 3'd2)
    begin
      // bypass forms: no unlock prefix
      seq_data = (op_r == fbe_pkg::FBE_OP_PROGRAM) ? fbe_pkg::CMD_PROGRAM
                                                   : fbe_pkg::CMD_ERASE_SETUP;
      if (idx_r == 3'd1)
      begin
        seq_addr = (op_r == fbe_pkg::FBE_OP_PROGRAM) ? caddr_r : fbe_pkg::ADDR_UNLOCK1;
        seq_data = (op_r == fbe_pkg::FBE_OP_PROGRAM) ? cdata_r[7:0]
                                                     : fbe_pkg::CMD_CHIP_ERASE;  // R06
      end
    end
    else if (idx_r == 3'd1 || idx_r == 3'd4)
    begin
      seq_addr = fbe_pkg::ADDR_UNLOCK2;
      seq_data = fbe_pkg::CMD_UNLOCK2;
    end
    else if (idx_r == 3'd2)
    begin
      seq_data = (op_r == fbe_pkg::FBE_OP_BYP_ENTER) ? fbe_pkg::CMD_BYPASS
               : (op_r == fbe_pkg::FBE_OP_PROGRAM)   ? fbe_pkg::CMD_PROGRAM
               : fbe_pkg::CMD_ERASE_SETUP;                   // R09 R16
    end
    else if (idx_r == 3'd3 && op_r == fbe_pkg::FBE_OP_PROGRAM)
    begin
      seq_addr = caddr_r;
      seq_data = cdata_r[7:0];
    end
    else if (idx_r == 3'd5)
    begin
      seq_addr = (op_r == fbe_pkg::FBE_OP_SECT_ERASE) ? caddr_r : fbe_pkg::ADDR_UNLOCK1;
      seq_data = (op_r == fbe_pkg::FBE_OP_SECT_ERASE) ? fbe_pkg::CMD_SECT_ERASE
                                                      : fbe_pkg::CMD_CHIP_ERASE;  // R17
    end
    // program data cycle carries the full word
    seq_word = {24'h000000, seq_data};
    if (op_r == fbe_pkg::FBE_OP_PROGRAM && last_cycle)
      seq_word = cdata_r;
  end

  // command sequencer
  always_comb
  begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    len_nxt   = len_r;
    op_nxt    = op_r;
    caddr_nxt = caddr_r;
    cdata_nxt = cdata_r;
    byp_nxt   = byp_r;
    more_nxt  = more_r;
    done_nxt  = 1'b0;
    rej_nxt   = 1'b0;
    wait_nxt  = wait_r;
    wr_start  = 1'b0;
    cmd_ready = 1'b0;
    unique case (state_r)
      FBE_IDLE:
      begin
        cmd_ready = 1'b1;
        if (cmd_valid && !accept)
          rej_nxt = 1'b1;                                   // R03 R05
        else if (cmd_valid)
        begin
          op_nxt    = cmd_op;
          caddr_nxt = cmd_addr;
          cdata_nxt = cmd_data;
          more_nxt  = cmd_more;
          len_nxt   = seq_len(cmd_op, byp_r);
          idx_nxt   = 3'd0;
          state_nxt = FBE_ISSUE;
        end
      end
      FBE_ISSUE:
      begin
        wr_start = !wr_busy && !wr_done;
        if (wr_done)
        begin
          if (!last_cycle)
            idx_nxt = idx_r + 3'd1;                         // R09 R16
          else
          begin
            if (op_r == fbe_pkg::FBE_OP_BYP_ENTER) byp_nxt = 1'b1;  // R01
            if (op_r == fbe_pkg::FBE_OP_BYP_EXIT)  byp_nxt = 1'b0;  // R04
            wait_nxt = 4'hf;
            if (op_r == fbe_pkg::FBE_OP_SECT_ERASE && more_r)
              state_nxt = FBE_SECT_MORE;                     // R18
            else if (op_r == fbe_pkg::FBE_OP_PROGRAM ||
                     op_r == fbe_pkg::FBE_OP_CHIP_ERASE ||
                     op_r == fbe_pkg::FBE_OP_SECT_ERASE)
              state_nxt = FBE_WAIT_BUSY;                     // R12
            else
            begin
              done_nxt  = 1'b1;
              state_nxt = FBE_IDLE;
            end
          end
        end
      end
      FBE_SECT_MORE:
      begin
        // only further sector addresses are taken, back to back
        cmd_ready = 1'b1;
        if (cmd_valid && cmd_op == fbe_pkg::FBE_OP_SECT_ERASE)
        begin
          caddr_nxt = cmd_addr;                             // R18 R20
          more_nxt  = cmd_more;
          idx_nxt   = 3'd5;
          state_nxt = FBE_ISSUE;
        end
        else if (cmd_valid)
          rej_nxt = 1'b1;
      end
      FBE_WAIT_BUSY:
      begin
        // pin needs a few cycles plus the synchroniser to show busy
        if (!rb_sync_r)
          state_nxt = FBE_WAIT_READY;                       // R13
        else if (wait_r == 4'h0)
          state_nxt = FBE_WAIT_READY;
        else
          wait_nxt = wait_r - 4'h1;
      end
      FBE_WAIT_READY:
        if (rb_sync_r)
        begin
          done_nxt  = 1'b1;                                 // R10 R14 R15 R23 R24
          state_nxt = FBE_IDLE;
        end
      default:
        state_nxt = FBE_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= FBE_IDLE;
      idx_r   <= 3'd0;
      len_r   <= 3'd1;
      op_r    <= fbe_pkg::FBE_OP_RESET;
      caddr_r <= '0;
      cdata_r <= '0;
      byp_r   <= 1'b0;                                      // R11
      more_r  <= 1'b0;
      done_r  <= 1'b0;
      rej_r   <= 1'b0;
      wait_r  <= 4'h0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      op_r    <= op_nxt;
      caddr_r <= caddr_nxt;
      cdata_r <= cdata_nxt;
      byp_r   <= byp_nxt;
      more_r  <= more_nxt;
      done_r  <= done_nxt;
      rej_r   <= rej_nxt;
      wait_r  <= wait_nxt;
    end
  end

  fbe_bus_write u_wr
  (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .start      (wr_start),
    .addr       (seq_addr),
    .data       (seq_word),
    .busy       (wr_busy),
    .done       (wr_done),
    .fl_we_n    (fl_we_n),
    .fl_ce_n    (fl_ce_n),
    .fl_addr    (fl_addr),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n)
  );

  assign cmd_done      = done_r;
  assign cmd_rejected  = rej_r;
  assign bypass_active = byp_r;
  assign fl_reset_n    = reset_n;

  // checks
  property p_byp_reject;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && state_r == FBE_IDLE && cmd_valid && byp_r && secure_sector &&
       cmd_op == fbe_pkg::FBE_OP_PROGRAM) |=> rej_r;
  endproperty
  a_byp_reject: assert property (p_byp_reject) else $error("program accepted under secure sector"); // R05

  property p_no_start_in_wait;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_r == FBE_WAIT_READY) |-> !wr_start;
  endproperty
  a_no_start_in_wait: assert property (p_no_start_in_wait) else $error("write during erase"); // R14

  property p_done_on_ready;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && state_r == FBE_WAIT_READY && rb_sync_r) |=> done_r;
  endproperty
  a_done_on_ready: assert property (p_done_on_ready) else $error("no done at ready"); // R24

  property p_bypass_enter;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && state_r == FBE_ISSUE && wr_done && last_cycle &&
       op_r == fbe_pkg::FBE_OP_BYP_ENTER) |=> byp_r;
  endproperty
  a_bypass_enter: assert property (p_bypass_enter) else $error("bypass not entered"); // R01

endmodule

/* fbe_flash_model.sv */
`timescale 1ns/1ps
// behavioural flash device: decodes write cycles, drives ready/busy
module fbe_flash_model
#(
  parameter int BUSY_CYC = 40,
  parameter int WIN_CYC  = 8000
)
(
  input  wire logic        ref_clk,
  input  wire logic        fl_reset_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_ce_n,
  input  wire logic [18:0] fl_addr,
  input  wire logic [31:0] fl_dq_out,
  input  wire logic        fl_dq_oe_n,
  input  wire logic        secure_sector,
  output logic             ready_busy_out,
  output logic             bypass_mode,
  output logic [2:0]       last_op,
  output logic [7:0]       op_count,
  output logic [7:0]       sect_count,
  output logic [7:0]       bad_count,
  output logic [18:0]      prog_addr,
  output logic [31:0]      prog_data
);
  logic        idle_q;
  logic [18:0] lat_addr;
  logic [7:0]  cyc [0:5];
  logic [18:0] cad [0:5];
  logic [31:0] wd;
  int          n;
  int          busy_cnt;
  int          win_cnt;
  logic        idle;

  // a write pulse ends when the first strobe rises
  assign idle = fl_we_n | fl_ce_n;

  // record one accepted command and start its busy time
  task automatic fin(input logic [2:0] op, input int busy);
    last_op  <= op;
    op_count <= op_count + 8'h01;
    busy_cnt = busy;
    n        = 0;
  endtask

  // sequence outside the command set is dropped
  task automatic drop;
    bad_count <= bad_count + 8'h01;
    n         = 0;
  endtask

  // program address and data from the last cycle
  task automatic prog;
    prog_addr <= cad[n-1];
    prog_data <= wd;
    fin(fbe_pkg::FBE_OP_PROGRAM, BUSY_CYC / 4);
  endtask

  // match the cycles gathered so far
  task automatic decode;
    logic [7:0] c;
    c = cyc[n-1];
    if (bypass_mode)
    begin
      if (n == 1 && c == 8'h98)
        fin(fbe_pkg::FBE_OP_CFI, 0);
      else if (n == 1 && !(c inside {8'ha0, 8'h80, 8'h90}))
        drop();
      else if (n == 2 && cyc[0] == 8'ha0 && !secure_sector)
        prog();
      else if (n == 2 && cyc[0] == 8'h80 && c == 8'h10)
        fin(fbe_pkg::FBE_OP_CHIP_ERASE, BUSY_CYC);
      else if (n == 2 && cyc[0] == 8'h90 && c == 8'h00)
      begin
        bypass_mode <= 1'b0;
        fin(fbe_pkg::FBE_OP_BYP_EXIT, 0);
      end
      else if (n == 2)
        drop();
    end
    else if (n == 1 && c == 8'h98 && cad[0] == 19'h00055)
      fin(fbe_pkg::FBE_OP_CFI, 0);
    else if (n == 1 && c == 8'hf0)
      fin(fbe_pkg::FBE_OP_RESET, 0);
    else if ((n == 1 && c != 8'haa) || (n == 2 && (c != 8'h55 || cad[1] != 19'h002aa)))
      drop();
    else if (n == 3 && c == 8'h20 && !secure_sector)
    begin
      bypass_mode <= 1'b1;
      fin(fbe_pkg::FBE_OP_BYP_ENTER, 0);
    end
    else if (n == 3 && !(c inside {8'ha0, 8'h80}))
      drop();
    else if (n == 4 && cyc[2] == 8'ha0)
      prog();
    else if ((n == 4 && c != 8'haa) || (n == 5 && c != 8'h55))
      drop();
    else if (n == 6 && c == 8'h10)
      fin(fbe_pkg::FBE_OP_CHIP_ERASE, BUSY_CYC);
    else if (n == 6 && c == 8'h30)
    begin
      fin(fbe_pkg::FBE_OP_SECT_ERASE, 0);
      sect_count <= 8'h01;
      win_cnt = WIN_CYC;
    end
    else if (n == 6)
      drop();
  endtask

  // strobe edges, busy countdown and decoding; hardware reset aborts
  always @(posedge ref_clk or negedge fl_reset_n)
  begin
    if (!fl_reset_n)
    begin
      idle_q         <= 1'b1;
      ready_busy_out <= 1'b1;
      bypass_mode    <= 1'b0;
      last_op        <= 3'h7;
      op_count       <= 8'h00;
      sect_count     <= 8'h00;
      bad_count      <= 8'h00;
      n        = 0;
      busy_cnt = 0;
      win_cnt  = 0;
    end
    else
    begin
      idle_q <= idle;
      if (idle_q && !idle)
        lat_addr <= fl_addr; // address held from the falling edge
      if (win_cnt > 0)
      begin
        win_cnt = win_cnt - 1;
        if (win_cnt == 0)
          busy_cnt = BUSY_CYC;
      end
      else if (busy_cnt > 0)
        busy_cnt = busy_cnt - 1;
      if (!idle_q && idle)
      begin
        if (fl_dq_oe_n)
          bad_count <= bad_count + 8'h01;
        if (win_cnt > 0 && fl_dq_out[7:0] == 8'h30)
        begin
          win_cnt = WIN_CYC;
          sect_count <= sect_count + 8'h01;
        end
        else if (win_cnt > 0 || busy_cnt > 0)
          bad_count <= bad_count + 8'h01;
        else
        begin
          cyc[n] = fl_dq_out[7:0];
          cad[n] = lat_addr;
          wd = fl_dq_out;
          n = n + 1;
          decode();
        end
      end
      ready_busy_out <= busy_cnt == 0 && win_cnt == 0;
    end
  end
endmodule

/* fbe_ctrl_tb.sv */
`timescale 1ns/1ps
// controller against the behavioural device
module fbe_ctrl_tb;
  localparam int LIMIT = 12000;
  logic              ref_clk;
  logic              reset_n;
  logic              clk_en;
  logic              cmd_valid;
  logic              cmd_ready;
  fbe_pkg::fbe_op_t  cmd_op;
  logic [18:0]       cmd_addr;
  logic [31:0]       cmd_data;
  logic              cmd_more;
  logic              secure_sector;
  logic              cmd_done;
  logic              cmd_rejected;
  logic              bypass_active;
  logic              fl_we_n;
  logic              fl_ce_n;
  logic              fl_reset_n;
  logic [18:0]       fl_addr;
  logic [31:0]       fl_dq_out;
  logic              fl_dq_oe_n;
  logic              ready_busy_out;
  logic              bypass_mode;
  logic [2:0]        last_op;
  logic [7:0]        op_count;
  logic [7:0]        sect_count;
  logic [7:0]        bad_count;
  logic [18:0]       prog_addr;
  logic [31:0]       prog_data;
  int                fails;
  int                comparisons;

  fbe_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_more(cmd_more), .secure_sector(secure_sector),
    .cmd_done(cmd_done), .cmd_rejected(cmd_rejected), .bypass_active(bypass_active),
    .fl_we_n(fl_we_n), .fl_ce_n(fl_ce_n), .fl_reset_n(fl_reset_n), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .ready_busy_out(ready_busy_out));

  fbe_flash_model #(.BUSY_CYC(40), .WIN_CYC(fbe_pkg::SECT_WIN_CYC)) device (
    .ref_clk(ref_clk), .fl_reset_n(fl_reset_n), .fl_we_n(fl_we_n), .fl_ce_n(fl_ce_n),
    .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n),
    .secure_sector(secure_sector), .ready_busy_out(ready_busy_out),
    .bypass_mode(bypass_mode), .last_op(last_op), .op_count(op_count),
    .sect_count(sect_count), .bad_count(bad_count), .prog_addr(prog_addr),
    .prog_data(prog_data));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic conclude;
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one request: wait for ready, hold valid over the take edge, await answer
  task automatic issue(input fbe_pkg::fbe_op_t op, input logic [18:0] a,
                       input logic [31:0] d, input logic more, input logic rej);
    int i;
    @(posedge ref_clk) #1 i = 0;
    while (cmd_ready !== 1'b1 && i < LIMIT)
    begin
      @(posedge ref_clk);
      #1 i++;
    end
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_addr  = a;
    cmd_data  = d;
    cmd_more  = more;
    @(posedge ref_clk);
    #1 cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && cmd_rejected !== 1'b1 && !(more && cmd_ready === 1'b1)
           && i < LIMIT)
    begin
      @(posedge ref_clk);
      #1 i++;
    end
    if (i >= LIMIT)
    begin
      fails++;
      conclude();
    end
    check(cmd_rejected, rej);
    check(cmd_done, !rej && !more);
  endtask

  // bypass entry, paired programs, refusals, query, bypass erase and exit
  task automatic t_bypass;
    issue(fbe_pkg::FBE_OP_BYP_ENTER, 19'h0, 32'h0, 1'b0, 1'b0);
    check(bypass_active, 1'b1);
    check(bypass_mode, 1'b1);
    issue(fbe_pkg::FBE_OP_PROGRAM, 19'h00123, 32'hcafe0001, 1'b0, 1'b0);
    issue(fbe_pkg::FBE_OP_PROGRAM, 19'h7fffe, 32'h5a5a0002, 1'b0, 1'b0);
    check(prog_addr, 19'h7fffe);
    check(prog_data, 32'h5a5a0002);
    check(op_count, 8'h03);
    secure_sector = 1'b1;
    issue(fbe_pkg::FBE_OP_PROGRAM, 19'h00200, 32'h1, 1'b0, 1'b1);
    secure_sector = 1'b0;
    issue(fbe_pkg::FBE_OP_SECT_ERASE, 19'h0, 32'h0, 1'b0, 1'b1);
    issue(fbe_pkg::FBE_OP_BYP_ENTER, 19'h0, 32'h0, 1'b0, 1'b1);
    issue(fbe_pkg::FBE_OP_RESET, 19'h0, 32'h0, 1'b0, 1'b1);
    issue(fbe_pkg::FBE_OP_CFI, 19'h0, 32'h0, 1'b0, 1'b0);
    check(last_op, fbe_pkg::FBE_OP_CFI);
    issue(fbe_pkg::FBE_OP_CHIP_ERASE, 19'h0, 32'h0, 1'b0, 1'b0);
    check(last_op, fbe_pkg::FBE_OP_CHIP_ERASE);
    check(ready_busy_out, 1'b1);
    issue(fbe_pkg::FBE_OP_BYP_EXIT, 19'h0, 32'h0, 1'b0, 1'b0);
    check(bypass_active, 1'b0);
    check(bypass_mode, 1'b0);
    check(op_count, 8'h06);
  endtask

  // secure sector blocks entry; standard refusals and chip erase
  task automatic t_chip;
    secure_sector = 1'b1;
    issue(fbe_pkg::FBE_OP_BYP_ENTER, 19'h0, 32'h0, 1'b0, 1'b1);
    check(bypass_mode, 1'b0);
    secure_sector = 1'b0;
    issue(fbe_pkg::FBE_OP_BYP_EXIT, 19'h0, 32'h0, 1'b0, 1'b1);
    issue(fbe_pkg::FBE_OP_RESET, 19'h0, 32'h0, 1'b0, 1'b0);
    check(last_op, fbe_pkg::FBE_OP_RESET);
    issue(fbe_pkg::FBE_OP_CHIP_ERASE, 19'h0, 32'h0, 1'b0, 1'b0);
    check(last_op, fbe_pkg::FBE_OP_CHIP_ERASE);
    check(ready_busy_out, 1'b1);
    issue(fbe_pkg::FBE_OP_PROGRAM, 19'h00777, 32'h12345678, 1'b0, 1'b0);
    check(prog_data, 32'h12345678);
  endtask

  // three sectors loaded inside the window, then one erase
  task automatic t_sector;
    issue(fbe_pkg::FBE_OP_SECT_ERASE, 19'h10000, 32'h0, 1'b1, 1'b0);
    check(ready_busy_out, 1'b0);
    issue(fbe_pkg::FBE_OP_CHIP_ERASE, 19'h0, 32'h0, 1'b0, 1'b1);
    issue(fbe_pkg::FBE_OP_SECT_ERASE, 19'h20000, 32'h0, 1'b1, 1'b0);
    issue(fbe_pkg::FBE_OP_SECT_ERASE, 19'h04000, 32'h0, 1'b0, 1'b0);
    check(sect_count, 8'h03);
    check(last_op, fbe_pkg::FBE_OP_SECT_ERASE);
    check(ready_busy_out, 1'b1);
  endtask

  // clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // main sequence
  initial
  begin
    reset_n       = 1'b0;
    clk_en        = 1'b1;
    cmd_valid     = 1'b0;
    cmd_op        = fbe_pkg::FBE_OP_PROGRAM;
    cmd_addr      = 19'h0;
    cmd_data      = 32'h0;
    cmd_more      = 1'b0;
    secure_sector = 1'b0;
    fails         = 0;
    comparisons   = 0;
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    check(cmd_ready, 1'b1);
    check(fl_we_n, 1'b1);
    check(fl_dq_oe_n, 1'b1);
    check(fl_ce_n, 1'b1);
    check(fl_reset_n, 1'b1);
    t_bypass();
    t_chip();
    t_sector();
    check(bad_count, 8'h00);
    issue(fbe_pkg::FBE_OP_BYP_ENTER, 19'h0, 32'h0, 1'b0, 1'b0);
    reset_n = 1'b0;
    #10 reset_n = 1'b1;
    check(bypass_active, 1'b0);
    check(bypass_mode, 1'b0);
    conclude();
  end
endmodule
